//--- rtl/bsc_pkg.sv
// Constants, types and commands shared by the borrow subtractor and compare block.
// Overview of operation
// RQ1 - Stage with both reflected bits one and no borrow drives low, setting its A bit.
// RQ2 - Both operand bits zero give half-difference one, borrow request upward, result one.
// RQ3 - Each stage output drives the set gates of both accumulator and shift register.
// RQ4 - Borrow request gate is one exactly when the stage itself must borrow.
// RQ5 - Borrow absorb gate is one when the stage satisfies a borrow without reborrowing.
// RQ6 - Propagate gate goes low on own request or an unabsorbed borrow from below.
// RQ7 - Normal path passes half-difference only when no lower borrow is outstanding.
// RQ8 - Borrow path is one for an unsatisfied incoming borrow; passes it and flips result.
// RQ9 - Of normal path and borrow path, one is always zero at each stage output.
// RQ10 - Index instruction variants test operand minus index value for a zero difference.
// RQ11 - Zero detect looks at paths of the lowest nine stages only; all zero means zero.
// RQ12 - Zero difference result goes to the skip command inverter of the timing chain.
// RQ13 - Zero detect output is used only during index register instructions.
// RQ14 - Divide subtracts divisor from dividend moved into the minuend by the left shift.
// RQ15 - Divisor above dividend causes end-around borrow and a quotient bit of zero.
// RQ16 - On end-around borrow, minuend goes back to accumulator before the next shift.
// RQ17 - Dividend not below divisor gates adder into accumulator and sets quotient bit.
// RQ18 - End-around borrow comes from top stage request or borrow passing it; feeds stage 0.
// RQ19 - Equal operands request no borrow; comparator reports greater-or-equal, bit one.
// RQ20 - Divide compare output is one exactly when an end-around borrow occurred.
// RQ21 - Minuend enters directly, each subtrahend bit in complemented form.
// RQ22 - Stage output one blocks the gate, so the cleared accumulator bit stays zero.
// RQ23 - Fifteen identical stages, weights one to two to the fourteenth, borrow wraps.
// RQ24 - Accumulator is cleared before each adder transfer so only low outputs set bits.
package bsc_pkg;

    // Word and field widths.
    localparam int WORD_W = 15;
    localparam int ZERO_BITS = 9;
    localparam int FC_W = 4;
    localparam int J_W = 2;

    // Instruction codes that steer the block.
    localparam logic [FC_W-1:0] FC_INDEX = 4'h6;
    localparam logic [FC_W-1:0] FC_DIVIDE = 4'h9;
    localparam logic [J_W-1:0] J_INDEX_A = 2'h1;
    localparam logic [J_W-1:0] J_INDEX_B = 2'h3;
    localparam logic [J_W-1:0] J_DIVIDE = 2'h3;

    // Reset and fill values of the word registers.
    localparam logic [WORD_W-1:0] WORD_ZERO = 15'h0000;
    localparam logic [WORD_W-1:0] WORD_ONES = 15'h7FFF;

    // One-cycle commands from the timing chain.
    typedef struct packed {
        logic load_x;
        logic load_d;
        logic clear_a;
        logic add_to_a;
        logic clear_s;
        logic add_to_s;
        logic div_step;
    } bsc_cmd_t;

    // Divide step sequence, one-hot.
    typedef enum logic [5:0] {
        ST_IDLE    = 6'h01,
        ST_SHIFT   = 6'h02,
        ST_CMP     = 6'h04,
        ST_RESTORE = 6'h08,
        ST_CLR     = 6'h10,
        ST_GATE    = 6'h20
    } bsc_state_t;

endpackage

//--- rtl/bsc_subtractor.sv
// Parallel subtractive adder with end-around borrow, zero detect and divide compare.
`timescale 1ns/1ps
module bsc_subtractor
    import bsc_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_b,
    // Instruction decode from control.
    input wire logic [FC_W-1:0] func_code,
    input wire logic [J_W-1:0] j_code,
    // Commands and operand word.
    input wire bsc_cmd_t cmd,
    input wire logic [WORD_W-1:0] operand_in,
    // Registers shown to the rest of the machine.
    output logic [WORD_W-1:0] minuend,
    output logic [WORD_W-1:0] subtrahend,
    output logic [WORD_W-1:0] accumulator,
    output logic [WORD_W-1:0] shift_reg,
    output logic [WORD_W-1:0] quotient,
    // Adder levels and the divide busy flag to the control section.
    output logic [WORD_W-1:0] stage_output_gate,
    output logic skip_command_inverter,
    output logic divide_compare_out,
    output logic divide_busy
);

    logic [WORD_W-1:0] x_r;
    logic [WORD_W-1:0] x_nxt;
    logic [WORD_W-1:0] d_r;
    logic [WORD_W-1:0] d_nxt;
    logic [WORD_W-1:0] a_r;
    logic [WORD_W-1:0] a_nxt;
    logic [WORD_W-1:0] s_r;
    logic [WORD_W-1:0] s_nxt;
    logic [WORD_W-1:0] q_r;
    logic [WORD_W-1:0] q_nxt;
    bsc_state_t state_r;
    bsc_state_t state_nxt;

    // Reflected operands and per-stage gates.
    logic [WORD_W-1:0] d_refl;
    logic [WORD_W-1:0] borrow_request_gate;
    logic [WORD_W-1:0] borrow_absorb_gate;
    logic [WORD_W-1:0] half_difference;
    logic [WORD_W-1:0] half_diff_inverter;
    logic [WORD_W-1:0] borrow_in [2];
    logic [WORD_W-1:0] borrow_propagate_gate [2];
    logic [WORD_W-1:0] borrow_path_gate [2];
    logic [WORD_W-1:0] normal_path_gate;
    logic [WORD_W-1:0] result;
    logic [1:0] wrap_in;
    logic end_around;
    logic zero_detect_gate;
    logic index_active;
    logic divide_active;

    // The subtrahend enters complemented, the minuend as stored.
    assign d_refl = ~d_r; // see RQ21

    // Stage-local gates; these do not depend on any borrow.
    assign borrow_request_gate = ~x_r & d_refl; // see RQ2, RQ4
    assign borrow_absorb_gate = x_r & ~d_refl; // see RQ5
    assign half_difference = x_r ^ d_refl; // see RQ2
    assign half_diff_inverter = ~half_difference;

    // The end-around borrow would be a combinational loop in one chain, so the
    // ripple is built twice: pass 0 with no wrap finds the wrap, pass 1 uses it.
    // One's-complement subtraction never wraps a second time, so two passes suffice.
    assign wrap_in[0] = 1'b0;
    assign wrap_in[1] = ~borrow_propagate_gate[0][WORD_W-1]; // see RQ18
    assign end_around = wrap_in[1]; // see RQ18

    // Fifteen identical stages per pass.
    generate
        for (genvar p = 0; p < 2; p++)
        begin : g_pass
            for (genvar i = 0; i < WORD_W; i++)
            begin : g_stage // see RQ23
                if (i == 0)
                begin : g_low
                    assign borrow_in[p][i] = wrap_in[p]; // see RQ18
                end
                else
                begin : g_up
                    assign borrow_in[p][i] = ~borrow_propagate_gate[p][i-1];
                end
                // Unsatisfied incoming borrow, not overridden by an own request.
                assign borrow_path_gate[p][i] = borrow_in[p][i]
                    & ~borrow_absorb_gate[i] & ~borrow_request_gate[i]; // see RQ8
                // Low on own request or on a borrow this stage cannot absorb.
                assign borrow_propagate_gate[p][i] =
                    ~(borrow_request_gate[i] | borrow_path_gate[p][i]); // see RQ6
            end
        end
    endgenerate

    // Normal path carries the half-difference only with no borrow from below.
    assign normal_path_gate = ~half_diff_inverter & ~borrow_in[1]; // see RQ7
    assign result = normal_path_gate | borrow_path_gate[1]; // see RQ8, RQ9
    // Output circuit is active low: a low level lets the set gate fire.
    assign stage_output_gate = ~result; // see RQ1, RQ22

    // Zero detect over the low nine stages of the final pass.
    assign zero_detect_gate = ~|(normal_path_gate[ZERO_BITS-1:0]
        | borrow_path_gate[1][ZERO_BITS-1:0]); // see RQ11

    // Instruction decode for the two users of the compare outputs.
    assign index_active = (func_code == FC_INDEX)
        && ((j_code == J_INDEX_A) || (j_code == J_INDEX_B)); // see RQ10
    assign divide_active = (func_code == FC_DIVIDE) && (j_code == J_DIVIDE); // see RQ14

    // Skip level only while an index instruction runs.
    assign skip_command_inverter = index_active & zero_detect_gate; // see RQ12, RQ13
    // One means dividend below divisor.
    assign divide_compare_out = end_around; // see RQ15, RQ20

    // Divide step sequencer and register next values.
    always_comb
    begin
        state_nxt = state_r;
        x_nxt = x_r;
        d_nxt = d_r;
        a_nxt = a_r;
        s_nxt = s_r;
        q_nxt = q_r;
        if (cmd.load_x)
        begin
            x_nxt = operand_in;
        end
        if (cmd.load_d)
        begin
            d_nxt = operand_in;
        end
        if (cmd.clear_a)
        begin
            a_nxt = WORD_ZERO; // see RQ24
        end
        else if (cmd.add_to_a)
        begin
            a_nxt = a_r | result; // see RQ1, RQ3, RQ22
        end
        if (cmd.clear_s)
        begin
            s_nxt = WORD_ZERO;
        end
        else if (cmd.add_to_s)
        begin
            s_nxt = s_r | result; // see RQ3
        end
        unique case (state_r)
            ST_IDLE:
            begin
                if (cmd.div_step && divide_active)
                begin
                    state_nxt = ST_SHIFT;
                end
            end
            ST_SHIFT:
            begin
                // Left shift of A and Q; the shifted A lands in the minuend.
                a_nxt = {a_r[WORD_W-2:0], q_r[WORD_W-1]};
                q_nxt = {q_r[WORD_W-2:0], 1'b0};
                x_nxt = {a_r[WORD_W-2:0], q_r[WORD_W-1]}; // see RQ14
                state_nxt = ST_CMP;
            end
            ST_CMP:
            begin
                if (end_around)
                begin
                    state_nxt = ST_RESTORE; // see RQ15
                end
                else
                begin
                    state_nxt = ST_CLR; // see RQ17, RQ19
                end
            end
            ST_RESTORE:
            begin
                // Quotient bit stays zero; A gets the unreduced dividend back.
                a_nxt = x_r; // see RQ16
                state_nxt = ST_IDLE;
            end
            ST_CLR:
            begin
                a_nxt = WORD_ZERO; // see RQ24
                state_nxt = ST_GATE;
            end
            ST_GATE:
            begin
                a_nxt = a_r | result; // see RQ17
                q_nxt = {q_r[WORD_W-1:1], 1'b1}; // see RQ17, RQ19
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // State registers.
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r <= ST_IDLE;
            x_r <= WORD_ZERO;
            d_r <= WORD_ZERO;
            a_r <= WORD_ZERO;
            s_r <= WORD_ZERO;
            q_r <= WORD_ZERO;
        end
        else
        begin
            state_r <= state_nxt;
            x_r <= x_nxt;
            d_r <= d_nxt;
            a_r <= a_nxt;
            s_r <= s_nxt;
            q_r <= q_nxt;
        end
    end

    // Register outputs.
    assign minuend = x_r;
    assign subtrahend = d_r;
    assign accumulator = a_r;
    assign shift_reg = s_r;
    assign quotient = q_r;
    assign divide_busy = (state_r != ST_IDLE);

    // Checks on the adder and the divide sequence.
    sequence s_take_gate;
        (state_r == ST_CLR) ##1 (state_r == ST_GATE) ##1 (state_r == ST_IDLE);
    endsequence

    sequence s_take_restore;
        (state_r == ST_RESTORE) ##1 (state_r == ST_IDLE);
    endsequence

    property p_agree_sets;
        @(posedge sys_clk) disable iff (!rst_b)
        (state_r == ST_IDLE && cmd.add_to_a && !cmd.clear_a && !cmd.load_x
            && !cmd.load_d && x_r == WORD_ONES && d_r == WORD_ONES)
        |=> (a_r == WORD_ONES);
    endproperty
    a_agree_sets: assert property (p_agree_sets) else $error("Agreeing ones did not set A."); // see RQ1

    property p_one_path_zero;
        @(posedge sys_clk) disable iff (!rst_b)
        (normal_path_gate & borrow_path_gate[1]) == WORD_ZERO;
    endproperty
    a_one_path_zero: assert property (p_one_path_zero) else $error("Both paths high."); // see RQ9

    property p_top_wraps;
        @(posedge sys_clk) disable iff (!rst_b)
        borrow_request_gate[WORD_W-1] |-> (divide_compare_out && borrow_in[1][0]);
    endproperty
    a_top_wraps: assert property (p_top_wraps) else $error("Top borrow did not wrap."); // see RQ18

    property p_equal_no_borrow;
        @(posedge sys_clk) disable iff (!rst_b)
        (half_difference == WORD_ZERO) |-> (!divide_compare_out && zero_detect_gate);
    endproperty
    a_equal_no_borrow: assert property (p_equal_no_borrow) else $error("Equal gave borrow."); // see RQ19

    property p_skip_only_index;
        @(posedge sys_clk) disable iff (!rst_b)
        skip_command_inverter |-> (func_code == FC_INDEX && j_code[0]);
    endproperty
    a_skip_only_index: assert property (p_skip_only_index) else $error("Skip outside index."); // see RQ13

    property p_shift_loads_x;
        @(posedge sys_clk) disable iff (!rst_b)
        (state_r == ST_SHIFT)
        |=> (x_r == a_r) && (x_r[WORD_W-1:1] == $past(a_r[WORD_W-2:0], 1))
            && (state_r == ST_CMP);
    endproperty
    a_shift_loads_x: assert property (p_shift_loads_x) else $error("Shift missed minuend."); // see RQ14

    property p_borrow_restores;
        @(posedge sys_clk) disable iff (!rst_b)
        (state_r == ST_CMP && divide_compare_out)
        |=> s_take_restore ##0 (q_r[0] == 1'b0) ##0 (a_r == $past(x_r, 1));
    endproperty
    a_borrow_restores: assert property (p_borrow_restores) else $error("Restore failed."); // see RQ16

    property p_accept_sets_q;
        @(posedge sys_clk) disable iff (!rst_b)
        (state_r == ST_CMP && !divide_compare_out)
        |=> s_take_gate ##0 q_r[0];
    endproperty
    a_accept_sets_q: assert property (p_accept_sets_q) else $error("Quotient bit not set."); // see RQ17

    property p_clear_first;
        @(posedge sys_clk) disable iff (!rst_b)
        (state_r == ST_GATE) |-> (a_r == WORD_ZERO) ##1 (a_r == ~$past(stage_output_gate));
    endproperty
    a_clear_first: assert property (p_clear_first) else $error("A not cleared first."); // see RQ22, RQ24

    // A step under any other decode must leave the sequencer idle.
    property p_refused_step;
        @(posedge sys_clk) disable iff (!rst_b)
        (state_r == ST_IDLE && cmd.div_step && !divide_active) |=> (state_r == ST_IDLE);
    endproperty
    a_refused_step: assert property (p_refused_step) else $error("Step outside divide."); // see RQ14

    // A step under the divide decode must start the left shift at once.
    property p_step_starts;
        @(posedge sys_clk) disable iff (!rst_b)
        (state_r == ST_IDLE && cmd.div_step && divide_active) |=> (state_r == ST_SHIFT);
    endproperty
    a_step_starts: assert property (p_step_starts) else $error("Step did not start."); // see RQ14

endmodule

//--- tb/bsc_ctl_model.sv
// Control-section model that drives instruction codes, command pulses and operands.
`timescale 1ns/1ps
module bsc_ctl_model
    import bsc_pkg::*;
(
    // Clock and status.
    input wire logic sys_clk,
    input wire logic divide_busy,
    // Decode, commands and operand.
    output logic [FC_W-1:0] func_code,
    output logic [J_W-1:0] j_code,
    output bsc_cmd_t cmd,
    output logic [WORD_W-1:0] operand_in
);
    // All lines quiet from time zero, so nothing is taken during reset.
    initial
    begin
        func_code = 4'h0;
        j_code = 2'h0;
        cmd = '0;
        operand_in = 15'h0000;
    end

    // Holds one command across one edge; callers chain these back to back.
    task automatic send(input bsc_cmd_t c, input logic [WORD_W-1:0] w);
        cmd = c;
        operand_in = w;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic quiet();
        cmd = '0;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic set_instr(input logic [FC_W-1:0] f, input logic [J_W-1:0] j);
        func_code = f;
        j_code = j;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic load_xd(input logic [WORD_W-1:0] x, input logic [WORD_W-1:0] d);
        bsc_cmd_t c;
        c = '0;
        c.load_x = 1'b1;
        send(c, x);
        c = '0;
        c.load_d = 1'b1;
        send(c, d);
        quiet();
    endtask

    // The clear must come first, since the gate only ever sets bits.
    task automatic gate_adder();
        bsc_cmd_t c;
        c = '0;
        c.clear_a = 1'b1;
        c.clear_s = 1'b1;
        send(c, 15'h0000);
        c = '0;
        c.add_to_a = 1'b1;
        c.add_to_s = 1'b1;
        send(c, 15'h0000);
        quiet();
    endtask

    // One divide step; the wait is bounded so a stuck sequencer cannot hang.
    task automatic div_step(output int cyc);
        bsc_cmd_t c;
        c = '0;
        c.div_step = 1'b1;
        send(c, 15'h0000);
        quiet();
        cyc = 0;
        while (divide_busy === 1'b1 && cyc < 20)
        begin
            @(posedge sys_clk);
            #1;
            cyc++;
        end
    endtask
endmodule

//--- tb/test_borrow_subtractor_compare.sv
// Self-checking testbench for the borrow subtractor and compare block.
`timescale 1ns/1ps
module test_borrow_subtractor_compare;
    import bsc_pkg::*;

    logic sys_clk;
    logic rst_b;
    logic [FC_W-1:0] func_code;
    logic [J_W-1:0] j_code;
    bsc_cmd_t cmd;
    logic [WORD_W-1:0] operand_in, minuend, subtrahend, accumulator, shift_reg, quotient;
    logic [WORD_W-1:0] stage_output_gate;
    logic skip_command_inverter, divide_compare_out, divide_busy;
    int bad_count = 0;
    int checks = 0;

    // Free-running 25 MHz clock.
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    bsc_ctl_model ctl (.sys_clk(sys_clk), .divide_busy(divide_busy), .func_code(func_code),
        .j_code(j_code), .cmd(cmd), .operand_in(operand_in));

    bsc_subtractor dut (.sys_clk(sys_clk), .rst_b(rst_b), .func_code(func_code),
        .j_code(j_code), .cmd(cmd), .operand_in(operand_in), .minuend(minuend),
        .subtrahend(subtrahend), .accumulator(accumulator), .shift_reg(shift_reg),
        .quotient(quotient), .stage_output_gate(stage_output_gate),
        .skip_command_inverter(skip_command_inverter),
        .divide_compare_out(divide_compare_out), .divide_busy(divide_busy));

    task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp,
        input string what);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Reference adder: returns {zero, end_around, result}; two passes close the wrap loop.
    function automatic logic [16:0] ref_sub(input logic [14:0] x, input logic [14:0] d);
        logic [14:0] req, ab, hs, bp, res, bi;
        logic bin, ea, z;
        req = ~x & ~d;
        ab = x & d;
        hs = x ^ ~d;
        ea = 1'b0;
        for (int p = 0; p < 2; p++)
        begin
            bin = ea;
            for (int i = 0; i < 15; i++)
            begin
                bi[i] = bin;
                bp[i] = bin & ~ab[i] & ~req[i];
                res[i] = bin ? bp[i] : hs[i];
                bin = req[i] | bp[i];
            end
            if (p == 0)
                ea = bin;
        end
        z = 1'b1;
        for (int i = 0; i < 9; i++)
            z = z & ~((~bi[i] & hs[i]) | bp[i]);
        return {z, ea, res};
    endfunction

    task automatic t_reset();
        chk(accumulator | minuend | subtrahend | shift_reg | quotient, 15'h0000, "regs");
        chk(stage_output_gate, 15'h7FFF, "reset gate");
        chk({13'h0000, divide_compare_out, skip_command_inverter}, 15'h0002, "flags");
        chk({14'h0000, divide_busy}, 15'h0000, "busy");
        $display("test reset done");
    endtask

    task automatic t_adder();
        logic [14:0] xs [8] = '{15'h7FFF, 15'h0000, 15'h1234, 15'h7F55, 15'h0000, 15'h4000,
            15'h2AAA, 15'h0001};
        logic [14:0] ds [8] = '{15'h7FFF, 15'h0000, 15'h5678, 15'h7EAA, 15'h7FFF, 15'h0000,
            15'h2AAA, 15'h7FFE};
        logic [16:0] r;
        for (int k = 0; k < 8; k++)
        begin
            r = ref_sub(xs[k], ds[k]);
            ctl.load_xd(xs[k], ds[k]);
            chk(subtrahend, ds[k], "d load");
            chk(stage_output_gate, ~r[14:0], "stage out");
            chk({14'h0000, divide_compare_out}, {14'h0000, r[15]}, "wrap");
            ctl.gate_adder();
            chk(accumulator, r[14:0], "acc gate");
            chk(shift_reg, r[14:0], "shift gate");
        end
        $display("test adder done");
    endtask

    task automatic t_skip();
        logic [3:0] fs [5] = '{4'h6, 4'h6, 4'h6, 4'h6, 4'h9};
        logic [1:0] js [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
        logic [14:0] ds [2] = '{15'h7EAA, 15'h7EAB};
        logic [16:0] r;
        logic e;
        for (int m = 0; m < 2; m++)
        begin
            r = ref_sub(15'h7F55, ds[m]);
            ctl.load_xd(15'h7F55, ds[m]);
            for (int k = 0; k < 5; k++)
            begin
                ctl.set_instr(fs[k], js[k]);
                e = r[16] & (fs[k] == 4'h6) & (js[k] == 2'h1 || js[k] == 2'h3);
                chk({14'h0000, skip_command_inverter}, {14'h0000, e}, "skip");
            end
        end
        $display("test skip done");
    endtask

    task automatic t_divide();
        logic [14:0] a0, a1, q0, d;
        logic [16:0] r;
        int cyc;
        ctl.set_instr(4'h0, 2'h0);
        ctl.load_xd(15'h0010, 15'h7FFF);
        ctl.gate_adder();
        chk(accumulator, 15'h0010, "prime");
        // A step under the index code must be ignored.
        ctl.set_instr(FC_INDEX, J_DIVIDE);
        ctl.div_step(cyc);
        chk(accumulator, 15'h0010, "refused");
        a0 = 15'h0010;
        q0 = 15'h0000;
        for (int k = 0; k < 2; k++)
        begin
            a1 = {a0[13:0], q0[14]};
            d = (k == 0) ? ~a1 : 15'h0000;
            ctl.load_xd(15'h0000, d);
            ctl.set_instr(FC_DIVIDE, J_DIVIDE);
            ctl.div_step(cyc);
            r = ref_sub(a1, d);
            chk({14'h0000, divide_busy}, 15'h0000, "busy end");
            chk(minuend, a1, "shift to x");
            chk({14'h0000, divide_compare_out}, {14'h0000, r[15]}, "cmp");
            a0 = r[15] ? a1 : r[14:0];
            q0 = {q0[13:0], ~r[15]};
            chk(accumulator, a0, "div acc");
            chk(quotient, q0, "quotient");
        end
        $display("test divide done");
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Watchdog: the tests need well under a thousand cycles.
    initial
    begin
        #(40 * 20000);
        bad_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        wrap_up();
    end

    // Main sequence: reset for 16 cycles, then each scenario in turn.
    initial
    begin
        rst_b = 1'b0;
        repeat (16) @(posedge sys_clk);
        #1;
        rst_b = 1'b1;
        t_reset();
        t_adder();
        t_skip();
        t_divide();
        wrap_up();
    end
endmodule
